// ---- core/fpl_consts.svh ----
// Offsets, field positions, reset values and timing figures of the front-panel block
`ifndef FPL_CONSTS_SVH
`define FPL_CONSTS_SVH
`define FPL_IO_ADDR_W 16
`define FPL_OUT_BYTE1_ADDR 16'h0435
`define FPL_OUT_BYTE3_ADDR 16'h0437
`define FPL_USER1_BIT 4
`define FPL_USER2_BIT 0
`define FPL_SEL_HI 6
`define FPL_SEL_LO 5
`define FPL_OUT_BYTE1_RST 8'h00
`define FPL_OUT_BYTE3_RST 8'h60
`define FPL_UNMAPPED_RDATA 8'h00
`define FPL_SEL_SOLID_GREEN 2'h0
`define FPL_SEL_BLINK_GREEN 2'h1
`define FPL_SEL_SOLID_AMBER 2'h2
`define FPL_SEL_BLINK_AMBER 2'h3
`define FPL_CLK_HZ 100000000
`define FPL_POWER_OFF_HOLD_S 4
`define FPL_DEBOUNCE_MS 10
`define FPL_BLINK_HALF_MS 500
`define FPL_ACT_BLINK_HALF_MS 50
`endif

// ---- core/fpl_pkg.sv ----
// Types shared by the front-panel modules
package fpl_pkg;
  typedef logic [1:0] fpl_sel_t;
  typedef logic [7:0] fpl_byte_t;
  typedef logic [31:0] fpl_cnt_t;
endpackage : fpl_pkg

// ---- core/fpl_sw_if.sv ----
// Carrier between a switch debouncer and the panel logic
`timescale 1ns/1ns
`default_nettype none
interface fpl_sw_if;
  logic pin_n;
  logic level;
  logic press;
  modport deb (input pin_n, output level, output press);
  modport user (output pin_n, input level, input press);
endinterface : fpl_sw_if
`default_nettype wire

// ---- core/fpl_debounce.sv ----
// Synchroniser and debouncer for one active-low panel switch
`timescale 1ns/1ns
`default_nettype none
module fpl_debounce
  import fpl_pkg::*;
#(
  parameter fpl_cnt_t CYC = 32'd1000000
)(
  input wire logic clk_i,
  input wire logic resetn_i,
  fpl_sw_if.deb sw
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic press;
    fpl_cnt_t cnt;
  } fpl_deb_s;

  fpl_deb_s st_r;
  fpl_deb_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // Raw pin goes straight into the sync pair; inversion only after it
    st_nxt.s1 = sw.pin_n;
    st_nxt.s2 = st_r.s1;
    st_nxt.press = 1'b0;
    if ((!st_r.s2) != st_r.level)
    begin
      st_nxt.cnt = st_r.cnt + 32'd1;
      // Level changes only after a full quiet interval
      if (st_r.cnt >= CYC - 32'd1)
      begin
        st_nxt.cnt = '0;
        st_nxt.level = !st_r.s2;
        st_nxt.press = !st_r.s2;
      end
    end
    else
    begin
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      // Sync pair starts at the released level, so no false press after reset
      st_r <= '0;
      st_r.s1 <= 1'b1;
      st_r.s2 <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sw.level = st_r.level;
  assign sw.press = st_r.press;
endmodule : fpl_debounce
`default_nettype wire

// ---- core/fpl_front_panel.sv ----
// Front-panel LED and push-button control with its output-byte registers
`timescale 1ns/1ns
`default_nettype none
`include "fpl_consts.svh"
module fpl_front_panel
  import fpl_pkg::*;
#(
  parameter fpl_cnt_t HOLD_OFF_CYC = `FPL_POWER_OFF_HOLD_S * `FPL_CLK_HZ,
  parameter fpl_cnt_t DEBOUNCE_CYC = `FPL_DEBOUNCE_MS * (`FPL_CLK_HZ / 1000),
  parameter fpl_cnt_t BLINK_HALF_CYC = `FPL_BLINK_HALF_MS * (`FPL_CLK_HZ / 1000),
  parameter fpl_cnt_t ACT_HALF_CYC = `FPL_ACT_BLINK_HALF_MS * (`FPL_CLK_HZ / 1000)
)(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [`FPL_IO_ADDR_W-1:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic power_sw_n_i,
  input wire logic sleep_sw_n_i,
  input wire logic reset_sw_n_i,
  input wire logic nmi_button_line_n_i,
  input wire logic [2:0] disk_act_i,
  input wire logic [1:0] lan_link_i,
  input wire logic [1:0] lan_act_i,
  input wire logic [1:0] lan_speed100_i,
  output logic power_led_o,
  output logic fault_led_o,
  output logic user_led_one_output_o,
  output logic user_led_two_output_o,
  output logic disk_led_o,
  output logic [1:0] lan_act_led_o,
  output logic [1:0] lan_speed_led_o,
  output logic power_on_req_o,
  output logic power_off_req_o,
  output logic sleep_req_o,
  output logic sys_reset_o,
  output logic nmi_o
);
  typedef struct packed {
    fpl_byte_t out_byte1;
    fpl_byte_t out_byte3;
    fpl_byte_t rdata;
    logic [8:0] s1;
    logic [8:0] s2;
    fpl_cnt_t blink_cnt;
    logic blink;
    fpl_cnt_t act_cnt;
    logic act_blink;
    logic [1:0] act_seen;
    fpl_cnt_t hold_cnt;
    logic off_done;
    logic power_led;
    logic fault_led;
    logic user1;
    logic user2;
    logic disk;
    logic [1:0] act_led;
    logic [1:0] spd_led;
    logic on_req;
    logic off_req;
    logic sleep_req;
    logic rst_req;
    logic nmi;
  } fpl_top_s;

  fpl_top_s st_r;
  fpl_top_s st_nxt;

  fpl_sw_if pwr_sw();
  fpl_sw_if slp_sw();
  fpl_sw_if rst_sw();
  fpl_sw_if nmi_sw();

  assign pwr_sw.pin_n = power_sw_n_i;
  assign slp_sw.pin_n = sleep_sw_n_i;
  assign rst_sw.pin_n = reset_sw_n_i;
  assign nmi_sw.pin_n = nmi_button_line_n_i;

  fpl_debounce #(.CYC(DEBOUNCE_CYC)) u_pwr_deb (.clk_i(clk_i), .resetn_i(resetn_i), .sw(pwr_sw.deb));
  fpl_debounce #(.CYC(DEBOUNCE_CYC)) u_slp_deb (.clk_i(clk_i), .resetn_i(resetn_i), .sw(slp_sw.deb));
  fpl_debounce #(.CYC(DEBOUNCE_CYC)) u_rst_deb (.clk_i(clk_i), .resetn_i(resetn_i), .sw(rst_sw.deb));
  fpl_debounce #(.CYC(DEBOUNCE_CYC)) u_nmi_deb (.clk_i(clk_i), .resetn_i(resetn_i), .sw(nmi_sw.deb));

  // Half-period divider step; reports the wrap, the caller clears the count
  function automatic logic div_wrap(input fpl_cnt_t cnt, input fpl_cnt_t half);
    div_wrap = (cnt >= half - 32'd1);
  endfunction : div_wrap

  fpl_sel_t sel;
  logic [2:0] disk_s;
  logic [1:0] link_s;
  logic [1:0] act_s;
  logic [1:0] spd_s;

  assign sel = st_r.out_byte3[`FPL_SEL_HI:`FPL_SEL_LO];
  assign disk_s = st_r.s2[2:0];
  assign link_s = st_r.s2[4:3];
  assign act_s = st_r.s2[6:5];
  assign spd_s = st_r.s2[8:7];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {lan_speed100_i, lan_act_i, lan_link_i, disk_act_i};
    st_nxt.s2 = st_r.s1;

    if (io_wr_i && io_addr_i == `FPL_OUT_BYTE1_ADDR)
      st_nxt.out_byte1 = io_wdata_i;
    if (io_wr_i && io_addr_i == `FPL_OUT_BYTE3_ADDR)
      st_nxt.out_byte3 = io_wdata_i;
    // Read data held until the next read
    if (io_rd_i)
    begin
      if (io_addr_i == `FPL_OUT_BYTE1_ADDR)
        st_nxt.rdata = st_r.out_byte1;
      else if (io_addr_i == `FPL_OUT_BYTE3_ADDR)
        st_nxt.rdata = st_r.out_byte3;
      else
        st_nxt.rdata = `FPL_UNMAPPED_RDATA;
    end

    // Free-running dividers, never stopped so patterns stay in phase
    st_nxt.blink_cnt = st_r.blink_cnt + 32'd1;
    if (div_wrap(st_r.blink_cnt, BLINK_HALF_CYC))
    begin
      st_nxt.blink_cnt = '0;
      st_nxt.blink = ~st_r.blink;
    end
    st_nxt.act_cnt = st_r.act_cnt + 32'd1;
    st_nxt.act_seen = st_r.act_seen | act_s;
    if (div_wrap(st_r.act_cnt, ACT_HALF_CYC))
    begin
      st_nxt.act_cnt = '0;
      st_nxt.act_blink = ~st_r.act_blink;
      st_nxt.act_seen = act_s;
    end

    case (sel)
      `FPL_SEL_SOLID_GREEN:
      begin
        st_nxt.power_led = 1'b1;
        st_nxt.fault_led = 1'b0;
      end
      `FPL_SEL_BLINK_GREEN:
      begin
        st_nxt.power_led = st_r.blink;
        st_nxt.fault_led = 1'b0;
      end
      `FPL_SEL_SOLID_AMBER:
      begin
        st_nxt.power_led = 1'b0;
        st_nxt.fault_led = 1'b1;
      end
      `FPL_SEL_BLINK_AMBER:
      begin
        st_nxt.power_led = 1'b0;
        st_nxt.fault_led = st_r.blink;
      end
      default:
      begin
        st_nxt.power_led = 1'b0;
        st_nxt.fault_led = 1'b0;
      end
    endcase

    st_nxt.user1 = st_r.out_byte3[`FPL_USER1_BIT];
    st_nxt.user2 = st_r.out_byte1[`FPL_USER2_BIT];
    st_nxt.disk = |disk_s;
    // Traffic darkens the LED on alternate phases, so traffic seen in a phase with act_blink high makes it blink at the fixed rate
    st_nxt.act_led = link_s & ~(st_r.act_seen & {2{st_r.act_blink}});
    st_nxt.spd_led = spd_s;

    st_nxt.on_req = pwr_sw.press;
    st_nxt.off_req = 1'b0;
    if (pwr_sw.level)
    begin
      if (!st_r.off_done)
        st_nxt.hold_cnt = st_r.hold_cnt + 32'd1;
      // One off request per hold, however long the button stays down
      if (!st_r.off_done && st_r.hold_cnt >= HOLD_OFF_CYC - 32'd1)
      begin
        st_nxt.off_req = 1'b1;
        st_nxt.off_done = 1'b1;
      end
    end
    else
    begin
      st_nxt.hold_cnt = '0;
      st_nxt.off_done = 1'b0;
    end
    st_nxt.sleep_req = slp_sw.press;
    st_nxt.rst_req = rst_sw.press;
    st_nxt.nmi = nmi_sw.level;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '0;
      st_r.out_byte1 <= `FPL_OUT_BYTE1_RST;
      st_r.out_byte3 <= `FPL_OUT_BYTE3_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata_o = st_r.rdata;
  assign power_led_o = st_r.power_led;
  assign fault_led_o = st_r.fault_led;
  assign user_led_one_output_o = st_r.user1;
  assign user_led_two_output_o = st_r.user2;
  assign disk_led_o = st_r.disk;
  assign lan_act_led_o = st_r.act_led;
  assign lan_speed_led_o = st_r.spd_led;
  assign power_on_req_o = st_r.on_req;
  assign power_off_req_o = st_r.off_req;
  assign sleep_req_o = st_r.sleep_req;
  assign sys_reset_o = st_r.rst_req;
  assign nmi_o = st_r.nmi;
endmodule : fpl_front_panel
`default_nettype wire

// ---- tb/fpl_monitor.sv ----
// Port assertions for the front-panel block
`timescale 1ns/1ns
`default_nettype none
module fpl_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic [2:0] disk_act_i,
  input wire logic power_led_o,
  input wire logic fault_led_o,
  input wire logic user_led_one_output_o,
  input wire logic user_led_two_output_o,
  input wire logic disk_led_o,
  input wire logic sys_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_user_one_bit: assert property (io_wr_i && io_addr_i == 16'h0437
    |-> ##2 user_led_one_output_o == $past(io_wdata_i[4], 2)) else $error("user led one wrong");
  chk_user_two_bit: assert property (io_wr_i && io_addr_i == 16'h0435
    |-> ##2 user_led_two_output_o == $past(io_wdata_i[0], 2)) else $error("user led two wrong");
  chk_sel_solid_green: assert property (io_wr_i && io_addr_i == 16'h0437 && io_wdata_i[6:5] == 2'h0
    |-> ##2 power_led_o && !fault_led_o) else $error("select 00 wrong");
  chk_sel_solid_amber: assert property (io_wr_i && io_addr_i == 16'h0437 && io_wdata_i[6:5] == 2'h2
    |-> ##2 !power_led_o && fault_led_o) else $error("select 10 wrong");
  chk_reset_leds_dark: assert property ($rose(resetn_i)
    |-> !user_led_one_output_o && !user_led_two_output_o && !power_led_o) else $error("leds lit at reset");
  chk_unmapped_zero: assert property (io_rd_i && io_addr_i != 16'h0435 && io_addr_i != 16'h0437
    |=> io_rdata_o == 8'h00) else $error("unmapped read not zero");
  // Guard skips the sync pipe still refilling after reset
  chk_disk_or_path: assert property ($past(resetn_i, 4)
    |-> disk_led_o == ($past(disk_act_i, 3) != 3'h0)) else $error("disk led wrong");
  chk_reset_one_pulse: assert property (sys_reset_o |=> !sys_reset_o) else $error("reset pulse too long");
endmodule : fpl_monitor
bind fpl_front_panel fpl_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .disk_act_i(disk_act_i), .power_led_o(power_led_o), .fault_led_o(fault_led_o),
  .user_led_one_output_o(user_led_one_output_o), .user_led_two_output_o(user_led_two_output_o),
  .disk_led_o(disk_led_o), .sys_reset_o(sys_reset_o));
`default_nettype wire

// ---- tb/fpl_panel_model.sv ----
// Front-panel push-button model
`timescale 1ns/1ns
`default_nettype none
module fpl_panel_model (
  input wire logic clk_i,
  output logic [3:0] sw_n_o
);
  // Pull-ups hold released buttons high
  initial sw_n_o = 4'hF;
  task automatic push(input int idx, input int cyc);
    @(negedge clk_i);
    sw_n_o[idx] = 1'b0;
    repeat (cyc) @(negedge clk_i);
    sw_n_o[idx] = 1'b1;
  endtask : push
endmodule : fpl_panel_model
`default_nettype wire

// ---- tb/tb_fpl_front_panel.sv ----
// Self-checking bench for the front-panel block
`timescale 1ns/1ns
`default_nettype none
module tb_fpl_front_panel;
  import fpl_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  fpl_byte_t io_wdata_i = 8'h00;
  fpl_byte_t rd;
  logic [2:0] disk_act_i = 3'h0;
  logic [1:0] link = 2'h0;
  logic [1:0] act = 2'h0;
  logic [1:0] spd = 2'h0;
  logic [1:0] act_led, spd_led;
  logic [3:0] sw_n;
  logic pwr, flt, u1, u2, dsk;
  logic [4:0] req;
  int errors = 0;
  int cmp_count = 0;
  int pc [5];
  fpl_panel_model pnl (.clk_i(clk_i), .sw_n_o(sw_n));
  fpl_front_panel #(.HOLD_OFF_CYC(50), .DEBOUNCE_CYC(4), .BLINK_HALF_CYC(8), .ACT_HALF_CYC(4)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(rd), .power_sw_n_i(sw_n[0]), .sleep_sw_n_i(sw_n[1]),
    .reset_sw_n_i(sw_n[2]), .nmi_button_line_n_i(sw_n[3]), .disk_act_i(disk_act_i), .lan_link_i(link),
    .lan_act_i(act), .lan_speed100_i(spd), .power_led_o(pwr), .fault_led_o(flt),
    .user_led_one_output_o(u1), .user_led_two_output_o(u2), .disk_led_o(dsk), .lan_act_led_o(act_led),
    .lan_speed_led_o(spd_led), .power_on_req_o(req[0]), .power_off_req_o(req[1]),
    .sleep_req_o(req[2]), .sys_reset_o(req[3]), .nmi_o(req[4]));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    for (int k = 0; k < 5; k++)
      pc[k] <= pc[k] + int'(req[k]);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk
  task automatic io(input logic w, input logic [15:0] a, input fpl_byte_t d);
    @(negedge clk_i);
    io_wr_i = w;
    io_rd_i = !w;
    io_addr_i = a;
    io_wdata_i = d;
    @(negedge clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask : io
  // Blink phase unknown, so count lit cycles over one full period
  task automatic leds(input fpl_byte_t ep, input fpl_byte_t ef);
    int p = 0;
    int f = 0;
    repeat (16)
    begin
      @(negedge clk_i);
      p += int'(pwr);
      f += int'(flt);
    end
    chk(8'(p), ep, "power led");
    chk(8'(f), ef, "fault led");
  endtask : leds
  task automatic t_reset;
    io(1'b0, 16'h0437, 8'h00);
    chk(rd, 8'h60, "byte three reset");
    io(1'b0, 16'h0435, 8'h00);
    chk(rd, 8'h00, "byte one reset");
    chk({6'h0, u1, u2}, 8'h00, "user leds reset");
    leds(8'h00, 8'h08);
    $display("reset test done");
  endtask : t_reset
  task automatic t_status;
    for (int i = 0; i < 4; i++)
    begin
      io(1'b1, 16'h0437, {1'b0, 2'(i), 5'h00});
      leds(i == 0 ? 8'h10 : i == 1 ? 8'h08 : 8'h00, i == 2 ? 8'h10 : i == 3 ? 8'h08 : 8'h00);
    end
    $display("status test done");
  endtask : t_status
  task automatic t_user;
    for (int i = 0; i < 4; i++)
    begin
      io(1'b1, 16'h0437, {3'h0, i[1], 4'h0});
      io(1'b1, 16'h0435, {7'h00, i[0]});
      io(1'b1, 16'h0436, 8'hFF);
      chk({6'h0, u1, u2}, 8'(i), "user leds");
      io(1'b0, 16'h0435, 8'h00);
      chk(rd, {7'h00, i[0]}, "byte one readback");
      io(1'b0, 16'h0436, 8'h00);
      chk(rd, 8'h00, "unmapped read");
    end
    $display("user test done");
  endtask : t_user
  task automatic t_switch;
    pc = '{default: 0};
    pnl.push(0, 20);
    pnl.push(1, 2);
    repeat (70) @(negedge clk_i);
    chk({8'(pc[0]), 8'(pc[1]), 8'(pc[2])}, 24'h010000, "short press");
    pnl.push(0, 90);
    pnl.push(1, 10);
    pnl.push(2, 10);
    pnl.push(3, 30);
    repeat (30) @(negedge clk_i);
    chk({8'(pc[0]), 8'(pc[1]), 8'(pc[2]), 8'(pc[3])}, 32'h02010101, "requests");
    chk(8'(pc[4] > 25 && pc[4] < 35), 8'h01, "nmi level");
    $display("switch test done");
  endtask : t_switch
  task automatic t_act;
    int n = 0;
    for (int i = 0; i < 3; i++)
    begin
      disk_act_i = 3'(1 << i);
      repeat (5) @(negedge clk_i);
      chk({7'h00, dsk}, 8'h01, "disk led");
    end
    disk_act_i = 3'h0;
    spd = 2'h2;
    link = 2'h1;
    repeat (5) @(negedge clk_i);
    chk({3'h0, dsk, act_led, spd_led}, 8'h06, "lan leds");
    act = 2'h1;
    // Firmware flags a fault: solid amber, not blinking
    io(1'b1, 16'h0437, 8'h40);
    leds(8'h00, 8'h10);
    // Steady traffic: lit for half of each blink period
    repeat (8)
    begin
      @(negedge clk_i);
      n += int'(act_led[0]);
    end
    chk(8'(n), 8'h04, "traffic blink");
    chk({7'h00, act_led[1]}, 8'h00, "no link dark");
    $display("activity test done");
  endtask : t_act
  task automatic summarize;
    $display("%0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    t_reset();
    t_status();
    t_user();
    t_switch();
    t_act();
    summarize();
  end
endmodule : tb_fpl_front_panel
`default_nettype wire
